// ===== design/rtc_trim_pkg.sv
// shared constants and types for the trimmed clock output block
package rtc_trim_pkg;
    // apb register byte offsets
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] trim_addr = 8'h04;
    localparam logic [7:0] status_addr = 8'h08;
    localparam logic [7:0] mask_addr = 8'h0c;
    localparam logic [7:0] pd_stamp_addr = 8'h10;
    localparam logic [7:0] pu_stamp_addr = 8'h14;
    localparam logic [7:0] state_addr = 8'h18;

    // reset values
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [7:0] trim_rst = 8'h00;
    localparam logic [1:0] mask_rst = 2'h0;
    localparam logic [31:0] stamp_rst = 32'h0000_0000;

    // status bit positions
    localparam int status_backup_bit = 0;
    localparam int status_restore_bit = 1;
    localparam int status_width = 2;

    // trim field layout
    localparam int trim_sign_bit = 7;
    localparam int trim_mag_width = 7;

    // divider lengths in oscillator cycles
    localparam logic [15:0] full_1hz = 16'h8000;
    localparam logic [15:0] half_1hz = 16'h4000;
    localparam logic [15:0] full_4k = 16'h0008;
    localparam logic [15:0] half_4k = 16'h0004;
    localparam logic [15:0] full_8k = 16'h0004;
    localparam logic [15:0] half_8k = 16'h0002;
    localparam logic [15:0] half_64hz = 16'h0100;
    localparam logic [15:0] one_cycle = 16'h0001;

    // rate select encodings of the two low bits
    localparam logic [1:0] rate_1hz = 2'h0;
    localparam logic [1:0] rate_4k = 2'h1;
    localparam logic [1:0] rate_8k = 2'h2;
    localparam logic [1:0] rate_32k = 2'h3;

    // control register layout
    typedef struct packed {
        logic out_level;
        logic square_wave_enable;
        logic [2:0] reserved;
        logic rate_select_high;
        logic rate_select_mid;
        logic rate_select_low;
    } ctrl_t;

    // supply monitor indications
    typedef struct packed {
        logic fail_pulse;
        logic restore_pulse;
    } supply_evt_t;

    // alarm logic feeding the pin
    typedef struct packed {
        logic active;
        logic level;
    } alarm_t;
endpackage : rtc_trim_pkg

// ===== design/sync_two_ff.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int width = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] meta_ff;
    logic [width-1:0] sync_ff;

    // meta_ff is read only by sync_ff
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : sync_two_ff

// ===== design/rtc_trim_clkout.sv
// trimmed clock output, pin function selection and power-fail time stamps
`timescale 1ns/1ps
// What this block does
// - low rate bits pick 32768, 8, 4 or 1 oscillator cycles per period
// - trim has no effect when the high rate bit is clear and low rate bits are 11
// - trimming only with non-zero magnitude; 00h and 80h mean none
// - 1 Hz mode: one period per minute is 32768 plus/minus twice magnitude
// - duty cycle of the corrected period need not be 50%
// - 4k/8k modes, positive sign: stall waveform once per minute, twice magnitude
// - 4k/8k modes, negative sign: removal bounded by the divider length
// - high rate bit set gives 512-cycle 64 Hz output, low bits ignored
// - 64 Hz mode trims every period: 2 x (256 plus/minus twice magnitude)
// - trim top bit is sign, one subtracts; low seven bits are magnitude
// - pin shows the level bit unless square wave enable picks the divider or an active alarm takes it
// - on backup supply only the alarm function drives the pin
// - refuse access below trip and backup; allow above trip threshold
// - on supply fail capture time into power-down stamp, set backup bit
// - on supply restore capture time into power-up stamp
// - clearing the backup bit clears both stamps
module rtc_trim_clkout (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_clk_in,
    input wire logic vcc_above_trip,
    input wire logic vcc_above_backup,
    input wire rtc_trim_pkg::supply_evt_t supply_evt,
    input wire logic minute_tick,
    input wire logic [31:0] current_time,
    input wire rtc_trim_pkg::alarm_t alarm,
    output logic multi_function_output,
    output logic host_access_ok,
    output logic irq
);
    import rtc_trim_pkg::*;

    logic osc_s;
    logic trip_s;
    logic backup_s;
    logic osc_prev_ff;
    logic tick;
    ctrl_t ctrl_ff;
    logic [7:0] trim_value_ff;
    logic [status_width-1:0] status_ff;
    logic [status_width-1:0] mask_ff;
    logic [31:0] pd_stamp_ff;
    logic [31:0] pu_stamp_ff;
    logic on_backup_ff;
    logic access_ok_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;
    logic mfp_ff;
    logic freq_ff;
    logic [15:0] cnt_ff;
    logic [7:0] stall_ff;
    logic minute_pending_ff;
    logic cur_trim_ff;
    logic trim_on;
    logic trim_neg;
    logic [7:0] mag2;
    logic [15:0] half_len;
    logic [15:0] full_len;
    logic [15:0] base_len;
    logic use_stall;
    logic wrap;
    logic access_phase;
    logic wr_en;
    logic addr_ok;
    logic status_clr_backup;
    logic [status_width-1:0] status_w1c;
    logic [31:0] nxt_rdata;

    sync_two_ff #(.width(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({osc_clk_in, vcc_above_trip, vcc_above_backup}),
        .sync_out({osc_s, trip_s, backup_s})
    );

    // apb slave: one wait state, answer on the second access cycle
    assign access_phase = psel && penable && !pready_ff;
    assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign status_w1c = (wr_en && paddr == status_addr) ? pwdata[status_width-1:0] : '0;
    assign status_clr_backup = status_w1c[status_backup_bit];

    always_comb begin
        addr_ok = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            ctrl_addr: nxt_rdata[7:0] = ctrl_ff;
            trim_addr: nxt_rdata[7:0] = trim_value_ff;
            status_addr: nxt_rdata[status_width-1:0] = status_ff;
            mask_addr: nxt_rdata[status_width-1:0] = mask_ff;
            pd_stamp_addr: nxt_rdata = pd_stamp_ff;
            pu_stamp_addr: nxt_rdata = pu_stamp_ff;
            state_addr: nxt_rdata[2:0] = {mfp_ff, access_ok_ff, on_backup_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= access_phase;
            if (access_phase) begin
                // refused while the supply forbids host access
                pslverr_ff <= !addr_ok || !access_ok_ff;
                prdata_ff <= (addr_ok && access_ok_ff && !pwrite) ? nxt_rdata : 32'h0000_0000;
            end else begin
                pslverr_ff <= 1'b0;
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= ctrl_rst;
            trim_value_ff <= trim_rst;
            mask_ff <= mask_rst;
        end else if (wr_en) begin
            case (paddr)
                ctrl_addr: ctrl_ff <= pwdata[7:0];
                trim_addr: trim_value_ff <= pwdata[7:0];
                mask_addr: mask_ff <= pwdata[status_width-1:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // supply state and access permission
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_ok_ff <= 1'b0;
            on_backup_ff <= 1'b0;
        end else begin
            access_ok_ff <= trip_s || backup_s;
            if (supply_evt.fail_pulse) begin
                on_backup_ff <= 1'b1;
            end else if (supply_evt.restore_pulse) begin
                on_backup_ff <= 1'b0;
            end
        end
    end

    // sticky status: a new event wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
        end else begin
            status_ff[status_backup_bit] <= supply_evt.fail_pulse
                || (status_ff[status_backup_bit] && !status_w1c[status_backup_bit]);
            status_ff[status_restore_bit] <= supply_evt.restore_pulse
                || (status_ff[status_restore_bit] && !status_w1c[status_restore_bit]);
        end
    end

    // one capture per pulse; a fail in the clearing cycle keeps its stamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_stamp_ff <= stamp_rst;
            pu_stamp_ff <= stamp_rst;
        end else begin
            if (supply_evt.fail_pulse) begin
                pd_stamp_ff <= current_time;
            end else if (status_clr_backup) begin
                pd_stamp_ff <= stamp_rst;
            end
            if (supply_evt.restore_pulse) begin
                pu_stamp_ff <= current_time;
            end else if (status_clr_backup) begin
                pu_stamp_ff <= stamp_rst;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // oscillator edge detect; only the divider relies on it, stamps do not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_s;
        end
    end
    assign tick = osc_s && !osc_prev_ff;

    assign trim_on = trim_value_ff[trim_mag_width-1:0] != '0;
    assign trim_neg = trim_value_ff[trim_sign_bit];
    assign mag2 = {trim_value_ff[trim_mag_width-1:0], 1'b0};

    // period lengths of the current mode
    always_comb begin
        half_len = half_1hz;
        full_len = full_1hz;
        base_len = full_1hz;
        use_stall = 1'b0;
        if (ctrl_ff.rate_select_high) begin
            // low bits ignored, every period trimmed
            half_len = half_64hz;
            if (trim_on) begin
                half_len = trim_neg ? half_64hz - 16'(mag2) : half_64hz + 16'(mag2);
            end
            full_len = 16'(half_len << 1);
        end else begin
            case ({ctrl_ff.rate_select_mid, ctrl_ff.rate_select_low})
                rate_1hz: begin
                    half_len = half_1hz;
                    full_len = full_1hz;
                    if (cur_trim_ff && trim_on) begin
                        // duty left uncorrected in the trimmed period
                        full_len = trim_neg ? full_1hz - 16'(mag2) : full_1hz + 16'(mag2);
                    end
                end
                rate_4k, rate_8k: begin
                    base_len = ctrl_ff.rate_select_low ? full_4k : full_8k;
                    half_len = ctrl_ff.rate_select_low ? half_4k : half_8k;
                    full_len = base_len;
                    if (trim_on && !trim_neg) begin
                        use_stall = 1'b1;
                    end else if (cur_trim_ff && trim_on) begin
                        // cannot shorten below one cycle
                        full_len = (16'(mag2) >= base_len) ? one_cycle : base_len - 16'(mag2);
                    end
                end
                rate_32k: begin
                    half_len = one_cycle;
                    full_len = one_cycle;
                end
                default: begin
                    half_len = half_1hz;
                    full_len = full_1hz;
                end
            endcase
        end
    end

    assign wrap = tick && stall_ff == '0 && cnt_ff >= full_len - one_cycle;

    // minute correction waits for the next period boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            minute_pending_ff <= 1'b0;
            cur_trim_ff <= 1'b0;
        end else begin
            if (wrap) begin
                cur_trim_ff <= minute_pending_ff;
            end
            minute_pending_ff <= minute_tick || (minute_pending_ff && !wrap);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            stall_ff <= '0;
        end else if (tick) begin
            if (stall_ff != '0) begin
                stall_ff <= stall_ff - 8'h01;
            end else if (wrap) begin
                cnt_ff <= '0;
                if (minute_pending_ff && use_stall) begin
                    stall_ff <= mag2;
                end
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_ff <= 1'b0;
        end else if (!ctrl_ff.rate_select_high
                     && {ctrl_ff.rate_select_mid, ctrl_ff.rate_select_low} == rate_32k) begin
            freq_ff <= osc_s;
        end else if (stall_ff == '0) begin
            freq_ff <= cnt_ff < half_len;
        end
    end

    // pin function: only the alarm survives on backup supply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mfp_ff <= 1'b0;
        end else if (on_backup_ff) begin
            mfp_ff <= alarm.active ? alarm.level : 1'b0;
        end else if (ctrl_ff.square_wave_enable) begin
            mfp_ff <= freq_ff;
        end else if (alarm.active) begin
            mfp_ff <= alarm.level;
        end else begin
            mfp_ff <= ctrl_ff.out_level;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign multi_function_output = mfp_ff;
    assign host_access_ok = access_ok_ff;
    assign irq = irq_ff;
endmodule : rtc_trim_clkout

// ===== bench/rtc_trim_clkout_assertions.sv
// port-level checks for the trimmed clock output block
`timescale 1ns/1ps
module rtc_trim_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic vcc_above_trip,
    input wire logic vcc_above_backup,
    input wire rtc_trim_pkg::supply_evt_t supply_evt,
    input wire rtc_trim_pkg::alarm_t alarm,
    input wire logic multi_function_output,
    input wire logic host_access_ok,
    input wire logic irq
);
    import rtc_trim_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("pready did not follow the access cycle");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside an answer");
    AST_REFUSE: assert property (psel && penable && !pready && !host_access_ok |=> pslverr)
        else $error("access taken while refused");
    AST_LOCKOUT: assert property ((!vcc_above_trip && !vcc_above_backup)[*4] |-> !host_access_ok)
        else $error("access allowed below trip and backup");
    AST_ALLOW: assert property (vcc_above_trip[*5] |-> host_access_ok)
        else $error("access refused above trip");
    AST_BACKUP_PIN: assert property (supply_evt.fail_pulse ##1 (!supply_evt.restore_pulse)[*4]
        |-> multi_function_output == $past(alarm.active && alarm.level))
        else $error("pin not driven by alarm on backup");
    // irq may only drop after a status clear or a mask write
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("irq fell without a register write");
endmodule : rtc_trim_chk
bind rtc_trim_clkout rtc_trim_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .vcc_above_trip, .vcc_above_backup, .supply_evt, .alarm, .multi_function_output,
    .host_access_ok, .irq);

// ===== bench/pin_watch.sv
// observer on the output pin: shortest and longest period in pclk cycles
`timescale 1ns/1ps
module pin_watch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic clr,
    output logic [15:0] max_ff,
    output logic [15:0] min_ff,
    output logic [15:0] edges_ff
);
    logic pin_ff;
    logic [15:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'h0;
            cnt_ff <= 16'h0;
            max_ff <= 16'h0;
            min_ff <= 16'hffff;
            edges_ff <= 16'h0;
        end else begin
            pin_ff <= pin;
            cnt_ff <= cnt_ff + 16'h1;
            if (clr) begin
                max_ff <= 16'h0;
                min_ff <= 16'hffff;
                edges_ff <= 16'h0;
            end else if (pin && !pin_ff) begin
                cnt_ff <= 16'h1;
                edges_ff <= edges_ff + 16'h1;
                // skip the partial period and the first whole one: a mode change may still ripple through it
                if (edges_ff > 16'h1 && cnt_ff > max_ff) max_ff <= cnt_ff;
                if (edges_ff > 16'h1 && cnt_ff < min_ff) min_ff <= cnt_ff;
            end
        end
    end
endmodule : pin_watch

// ===== bench/tb.sv
// self-checking bench for the trimmed clock output block
`timescale 1ns/1ps
module tb;
    import rtc_trim_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, osc_clk_in, vcc_above_trip, vcc_above_backup;
    logic minute_tick, pready, pslverr, multi_function_output, host_access_ok, irq, clr, rd_e;
    logic [7:0] paddr, c, t;
    logic [31:0] pwdata, prdata, current_time, seed, rd_v, tm;
    logic [15:0] max_per, min_per, edges;
    logic [1:0] osc_div;
    supply_evt_t supply_evt;
    alarm_t alarm;
    int failures, tests_run, cycles;
    rtc_trim_clkout DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .osc_clk_in, .vcc_above_trip, .vcc_above_backup, .supply_evt, .minute_tick,
        .current_time, .alarm, .multi_function_output, .host_access_ok, .irq);
    pin_watch watch (.pclk, .presetn, .pin(multi_function_output), .clr, .max_ff(max_per),
        .min_ff(min_per), .edges_ff(edges));
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // oscillator at pclk/8 keeps clear of the pclk/4 limit; it never stops
    always @(posedge pclk) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div == 2'h3) osc_clk_in <= ~osc_clk_in;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures++;
            summarize();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // pin period in pclk cycles, eight per oscillator cycle
    function logic [31:0] exp_per(input logic [7:0] cv, input logic [7:0] tv);
        logic [31:0] mag;
        mag = {25'h0, tv[6:0]};
        if (cv[2]) return tv[7] ? 32'h10 * (32'h100 - 32'h2 * mag) : 32'h10 * (32'h100 + 32'h2 * mag);
        return (cv[1:0] == 2'h1) ? 32'h40 : (cv[1:0] == 2'h2) ? 32'h20 : 32'h8;
    endfunction : exp_per
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd_v = prdata;
        rd_e = pslverr;
        if (n == 20) failures++;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(what, exp, rd_v);
    endtask : rd
    task measure(input logic tk, input logic [15:0] n);
        int k;
        k = 0;
        clr <= 1'h1;
        @(posedge pclk);
        clr <= 1'h0;
        @(posedge pclk);
        while (edges < 16'h2 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        minute_tick <= tk;
        @(posedge pclk);
        minute_tick <= 1'h0;
        while (edges < n && k < 40000) begin
            @(posedge pclk);
            k++;
        end
    endtask : measure
    task summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task pulse(input logic f, input logic [31:0] v);
        current_time <= v;
        supply_evt <= '{fail_pulse: f, restore_pulse: !f};
        @(posedge pclk);
        supply_evt <= '0;
        current_time <= rnd();
        repeat (6) @(posedge pclk);
    endtask : pulse
    initial begin
        {psel, penable, pwrite, minute_tick, clr, osc_clk_in, presetn} = '0;
        {paddr, pwdata, current_time, supply_evt, alarm, osc_div} = '0;
        {cycles, failures, tests_run} = '0;
        seed = 32'hd758;
        vcc_above_trip = 1'h1;
        vcc_above_backup = 1'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 6; i++) rd("reset_value", 8'(4 * i), 32'h0);
        rd("state_reset", state_addr, 32'h2);
        apb(1'h0, 8'h1c, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rd_e});
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, ctrl_addr, {24'h0, i[0], 7'h0});
            repeat (3) @(posedge pclk);
            chk("level_pin", {31'h0, i[0]}, {31'h0, multi_function_output});
        end
        // rates 01..11 and three trims of the 64 Hz mode
        for (int i = 0; i < 6; i++) begin
            c = (i < 3) ? 8'h41 + 8'(i) : 8'h44 | (8'(rnd()) & 8'h3);
            t = (i == 3) ? 8'h80 : 8'(rnd()) & 8'h8f;
            apb(1'h1, trim_addr, {24'h0, t});
            apb(1'h1, ctrl_addr, {24'h0, c});
            measure(1'h0, 16'h4);
            chk("period_min", exp_per(c, t), {16'h0, min_per});
            chk("period_max", exp_per(c, t), {16'h0, max_per});
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, trim_addr, i ? 32'h81 : 32'h02);
            apb(1'h1, ctrl_addr, 32'h41);
            measure(1'h1, 16'h7);
            chk("minute_max", i ? 32'h40 : 32'h60, {16'h0, max_per});
            chk("minute_min", i ? 32'h30 : 32'h40, {16'h0, min_per});
        end
        apb(1'h1, mask_addr, 32'h3);
        apb(1'h1, ctrl_addr, 32'hc3);
        tm = rnd();
        alarm <= '{active: 1'h1, level: tm[0]};
        pulse(1'h1, tm);
        chk("backup_pin", {31'h0, tm[0]}, {31'h0, multi_function_output});
        chk("irq_fail", 32'h1, {31'h0, irq});
        rd("pd_stamp", pd_stamp_addr, tm);
        rd("status_fail", status_addr, 32'h1);
        rd("state_backup", state_addr, {29'h0, tm[0], 2'h3});
        alarm <= '0;
        repeat (3) @(posedge pclk);
        // square wave is enabled, so a toggling pin here means it was not suspended
        chk("backup_quiet", 32'h0, {31'h0, multi_function_output});
        repeat (4) @(posedge pclk);
        chk("backup_quiet", 32'h0, {31'h0, multi_function_output});
        pulse(1'h0, ~tm);
        rd("pu_stamp", pu_stamp_addr, ~tm);
        rd("status_both", status_addr, 32'h3);
        apb(1'h1, mask_addr, 32'h0);
        @(posedge pclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'h1, status_addr, 32'h1);
        rd("pd_clear", pd_stamp_addr, 32'h0);
        rd("pu_clear", pu_stamp_addr, 32'h0);
        rd("status_left", status_addr, 32'h2);
        apb(1'h1, mask_addr, 32'h2);
        @(posedge pclk);
        chk("irq_restore", 32'h1, {31'h0, irq});
        apb(1'h1, status_addr, 32'h2);
        @(posedge pclk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        vcc_above_trip <= 1'h0;
        vcc_above_backup <= 1'h0;
        repeat (5) @(posedge pclk);
        chk("access_off", 32'h0, {31'h0, host_access_ok});
        apb(1'h1, trim_addr, 32'h55);
        chk("refused", 32'h1, {31'h0, rd_e});
        vcc_above_trip <= 1'h1;
        repeat (5) @(posedge pclk);
        rd("trim_kept", trim_addr, 32'h81);
        summarize();
    end
endmodule : tb
